// ---- design/sml_mode_ctrl.sv ----
// Mode control, serial load and shared test/lock pin of a dual synthesizer
//
// What this block does
// RULE1 - Serial load keeps working during any power-down
// RULE2 - Multiplier bit selects base or fourfold pump current
// RULE3 - Controller sets polarity to match oscillator slope
// RULE4 - High-impedance bit chooses drive and power-down style
// RULE5 - Both high selects clear: disabled or lock detect
// RULE6 - Lock output high when locked, combined needs both
// RULE7 - Single high select routes reference or feedback divider
// RULE8 - Fast-acquire switch grounds when main multiplier high
// RULE9 - Both high selects: counter resets, pumps high-impedance
// RULE10 - Released N counter restarts aligned with R
// RULE11 - Data MSB first, sampled on rising serial clock
// RULE12 - Fast acquire: fourfold current plus grounded resistor together
// RULE13 - Current change back applied in step with pump
// RULE14 - Mode bits fifteen to nineteen mapped per loop
// RULE15 - Address 00 aux latch, 10 main latch
// RULE16 - Load strobe rising moves 22-bit word into latch
// RULE17 - Power-down waits for pump pulse unless high-impedance
// RULE18 - Mode bits reset to zero before first load
`timescale 1ns/1ps
`default_nettype none

module sml_mode_ctrl (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic load_strobe,
    input wire sml_pkg::sml_loop_in_t aux_in,
    input wire sml_pkg::sml_loop_in_t main_in,
    output sml_pkg::sml_loop_out_t aux_out,
    output sml_pkg::sml_loop_out_t main_out,
    output logic shared_test_lock_pin_o,
    output logic shared_test_lock_pin_oe_b
);
    import sml_pkg::*;

    // Decode the pin function from both loops' select bits
    function automatic sml_sel_t sel_decode(input sml_mode_t aux, input sml_mode_t main);
        sml_sel_t sel;
        sel = SEL_OFF;
        if (!aux.sel_hi && !main.sel_hi) begin
            case ({main.sel_lo, aux.sel_lo})
                2'h1: sel = SEL_LD_AUX;
                2'h2: sel = SEL_LD_MAIN;
                2'h3: sel = SEL_LD_BOTH;
                default: sel = SEL_OFF;
            endcase
        end else if (aux.sel_hi && main.sel_hi) begin
            sel = (aux.sel_lo || main.sel_lo) ? SEL_RST : SEL_FAST;
        end else if (aux.sel_hi) begin
            sel = aux.sel_lo ? SEL_AUX_FB : SEL_AUX_REF;
        end else begin
            sel = aux.sel_lo ? SEL_MAIN_FB : SEL_MAIN_REF;
        end
        return sel;
    endfunction

    // Power-down sequencing: immediate with high-impedance, else after pump pulse
    function automatic sml_pd_t pd_next(input sml_pd_t cur, input logic req, input logic hiz,
                                        input logic busy);
        sml_pd_t nxt;
        nxt = cur;
        case (cur)
            PD_RUN: begin
                if (req) begin
                    nxt = (hiz || !busy) ? PD_DOWN : PD_WAIT;
                end
            end
            PD_WAIT: begin
                if (!req) begin
                    nxt = PD_RUN;
                end else if (hiz || !busy) begin
                    nxt = PD_DOWN;
                end
            end
            PD_DOWN: begin
                if (!req) begin
                    nxt = PD_RUN;
                end
            end
            default: nxt = PD_RUN;
        endcase
        return nxt;
    endfunction

    sml_link_st_t link_q;
    sml_link_st_t link_d;
    sml_ref_st_t st_q;
    sml_ref_st_t st_d;
    logic le_sync;
    logic le_rise;
    logic [SHIFT_W-1:0] word;
    sml_mode_t word_mode;
    sml_sel_t sel_now;

    // Serial clock domain: shift in, MSB first on the rising edge
    always_comb begin
        link_d = link_q;
        link_d.shift = {link_q.shift[SHIFT_W-2:0], ser_data}; // see RULE11
    end

    // Never gated by power-down so words load at any time
    always_ff @(posedge ser_clk or negedge rst_b) begin // see RULE1
        if (!rst_b) begin
            link_q.shift <= SHIFT_RESET;
        end else begin
            link_q <= link_d;
        end
    end

    // Load strobe is a pin: two flops before use
    sml_sync #(
        .WIDTH(1)
    ) u_le_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .d(load_strobe),
        .q(le_sync)
    );

    // The serial clock is idle while the strobe is high, so the word is quiet when read
    assign le_rise = le_sync && !st_q.le_prev; // see RULE16
    assign word = link_q.shift;
    assign word_mode = sml_mode_t'(word[BIT_SEL_HI:BIT_POL]); // see RULE14
    assign sel_now = sel_decode(st_q.aux_mode, st_q.main_mode);

    // Reference domain next state
    always_comb begin
        st_d = st_q;
        st_d.le_prev = le_sync;
        if (le_rise) begin
            case (word[ADDR_W-1:0])
                ADDR_AUX_R: st_d.aux_mode = word_mode; // see RULE15
                ADDR_MAIN_R: st_d.main_mode = word_mode; // see RULE15
                ADDR_AUX_N: st_d.aux_loop_power_down_bit = word[BIT_LOOP_POWER_DOWN_BIT];
                ADDR_MAIN_N: st_d.main_loop_power_down_bit = word[BIT_LOOP_POWER_DOWN_BIT];
                default: st_d.aux_loop_power_down_bit = st_q.aux_loop_power_down_bit;
            endcase
        end
        // Current level only changes between pump pulses, leaving filter charge alone
        if (!aux_in.pump_busy) begin
            st_d.aux_quad_app = st_q.aux_mode.quad; // see RULE13
        end
        if (!main_in.pump_busy) begin
            st_d.main_quad_app = st_q.main_mode.quad; // see RULE13
        end
        st_d.aux_pd = pd_next(st_q.aux_pd, st_q.aux_loop_power_down_bit, st_q.aux_mode.hiz, aux_in.pump_busy); // see RULE17
        st_d.main_pd = pd_next(st_q.main_pd, st_q.main_loop_power_down_bit, st_q.main_mode.hiz, main_in.pump_busy); // see RULE17

        // Counter resets drive R and N together, so release restarts both aligned
        st_d.aux_out.cnt_reset = (sel_now == SEL_RST) && st_q.aux_mode.sel_lo; // see RULE9 RULE10
        st_d.main_out.cnt_reset = (sel_now == SEL_RST) && st_q.main_mode.sel_lo; // see RULE9 RULE10
        st_d.aux_out.hiz = st_q.aux_mode.hiz || st_d.aux_out.cnt_reset; // see RULE4 RULE9
        st_d.main_out.hiz = st_q.main_mode.hiz || st_d.main_out.cnt_reset; // see RULE4 RULE9
        st_d.aux_out.quad = st_d.aux_quad_app; // see RULE2
        st_d.main_out.quad = st_d.main_quad_app; // see RULE2 RULE12
        st_d.aux_out.pol = st_q.aux_mode.pol;
        st_d.main_out.pol = st_q.main_mode.pol;
        st_d.aux_out.power_down = (st_d.aux_pd == PD_DOWN);
        st_d.main_out.power_down = (st_d.main_pd == PD_DOWN);

        // Shared pin: oe_b low means the pin is driven
        st_d.pin_o = 1'b0;
        st_d.pin_oe_b = 1'b1;
        case (sel_now)
            SEL_OFF: st_d.pin_oe_b = 1'b1; // see RULE5
            SEL_LD_AUX: st_d.pin_oe_b = aux_in.lock; // see RULE5 RULE6
            SEL_LD_MAIN: st_d.pin_oe_b = main_in.lock; // see RULE5 RULE6
            SEL_LD_BOTH: st_d.pin_oe_b = aux_in.lock && main_in.lock; // see RULE6
            SEL_AUX_REF: begin
                st_d.pin_o = aux_in.ref_div; // see RULE7
                st_d.pin_oe_b = 1'b0;
            end
            SEL_MAIN_REF: begin
                st_d.pin_o = main_in.ref_div; // see RULE7
                st_d.pin_oe_b = 1'b0;
            end
            SEL_AUX_FB: begin
                st_d.pin_o = aux_in.fb_div; // see RULE7
                st_d.pin_oe_b = 1'b0;
            end
            SEL_MAIN_FB: begin
                st_d.pin_o = main_in.fb_div; // see RULE7
                st_d.pin_oe_b = 1'b0;
            end
            // Switch follows the applied current so both change in one edge
            SEL_FAST: st_d.pin_oe_b = !st_d.main_quad_app; // see RULE8 RULE12
            SEL_RST: st_d.pin_oe_b = 1'b1;
            default: st_d.pin_oe_b = 1'b1;
        endcase
    end

    // Mode bits zero after reset, power-down in PD_RUN, pin off with oe_b high, normal base current
    always_ff @(posedge ref_clk or negedge rst_b) begin // see RULE18
        if (!rst_b) begin
            st_q <= '0;
            st_q.aux_mode <= MODE_RESET;
            st_q.main_mode <= MODE_RESET;
            st_q.aux_pd <= PD_RUN;
            st_q.main_pd <= PD_RUN;
            st_q.pin_oe_b <= PIN_OE_B_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign aux_out = st_q.aux_out;
    assign main_out = st_q.main_out;
    assign shared_test_lock_pin_o = st_q.pin_o;
    assign shared_test_lock_pin_oe_b = st_q.pin_oe_b;

    // Checks in the reference domain
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    chk_aux_load: assert property ( // see RULE15 RULE16 RULE1
        le_rise && word[ADDR_W-1:0] == ADDR_AUX_R |=> st_q.aux_mode == $past(word_mode))
        else $error("aux mode word not latched");

    chk_main_load: assert property ( // see RULE15 RULE16
        le_rise && word[ADDR_W-1:0] == ADDR_MAIN_R |=> ##1 main_out.pol == $past(word_mode.pol, 2))
        else $error("main polarity not applied after load");

    chk_quad_follow: assert property ( // see RULE2 RULE13
        !main_in.pump_busy |=> main_out.quad == $past(st_q.main_mode.quad))
        else $error("main pump current not applied while idle");

    chk_quad_hold: assert property ( // see RULE13
        aux_in.pump_busy |=> $stable(aux_out.quad))
        else $error("aux pump current changed during pump pulse");

    chk_hiz_drive: assert property ( // see RULE4
        st_q.aux_mode.hiz |=> aux_out.hiz)
        else $error("aux pump not high impedance");

    chk_pin_off: assert property ( // see RULE5 RULE18
        sel_now == SEL_OFF |=> shared_test_lock_pin_oe_b)
        else $error("shared pin driven while disabled");

    chk_lock_both: assert property ( // see RULE6
        sel_now == SEL_LD_BOTH && !(aux_in.lock && main_in.lock)
        |=> !shared_test_lock_pin_oe_b && !shared_test_lock_pin_o)
        else $error("combined lock shown with a loop unlocked");

    chk_div_route: assert property ( // see RULE7
        sel_now == SEL_AUX_FB |=> !shared_test_lock_pin_oe_b && shared_test_lock_pin_o == $past(aux_in.fb_div))
        else $error("aux feedback divider not on shared pin");

    chk_fast_pull: assert property ( // see RULE8 RULE12
        sel_now == SEL_FAST && !main_in.pump_busy && st_q.main_mode.quad
        |=> !shared_test_lock_pin_oe_b && main_out.quad)
        else $error("fast acquire switch not grounded with fourfold current");

    chk_cnt_reset: assert property ( // see RULE9 RULE10
        sel_now == SEL_RST && st_q.main_mode.sel_lo |=> main_out.cnt_reset && main_out.hiz)
        else $error("main counters not held in reset");

    // Power-down style follows the pump high-impedance bit of the same loop
    chk_pd_async: assert property ( // see RULE17
        st_q.aux_loop_power_down_bit && st_q.aux_mode.hiz |=> aux_out.power_down)
        else $error("aux power-down not immediate in high impedance");

    chk_pd_main_async: assert property ( // see RULE17
        st_q.main_loop_power_down_bit && st_q.main_mode.hiz |=> main_out.power_down)
        else $error("main power-down not immediate in high impedance");

    chk_pd_gated: assert property ( // see RULE17
        st_q.aux_pd == PD_RUN && st_q.aux_loop_power_down_bit && !st_q.aux_mode.hiz && aux_in.pump_busy
        |=> !aux_out.power_down)
        else $error("aux power-down cut a pump pulse");

    // Link domain: its own clock, so the default clocking is overridden
    chk_shift_in: assert property ( // see RULE11
        @(posedge ser_clk) disable iff (!rst_b)
        1'b1 |=> link_q.shift[0] == $past(ser_data) && link_q.shift[1] == $past(link_q.shift[0]))
        else $error("serial data not shifted in on rising edge");

    // Pin routing for the remaining selections
    chk_aux_lock: assert property ( // see RULE5 RULE6
        sel_now == SEL_LD_AUX
        |=> shared_test_lock_pin_oe_b == $past(aux_in.lock) && !shared_test_lock_pin_o)
        else $error("aux lock detect not on shared pin");

    chk_main_lock: assert property ( // see RULE5 RULE6
        sel_now == SEL_LD_MAIN
        |=> shared_test_lock_pin_oe_b == $past(main_in.lock) && !shared_test_lock_pin_o)
        else $error("main lock detect not on shared pin");

    chk_both_locked: assert property ( // see RULE6
        sel_now == SEL_LD_BOTH && aux_in.lock && main_in.lock
        |=> shared_test_lock_pin_oe_b)
        else $error("combined lock not shown with both loops locked");

    chk_aux_ref: assert property ( // see RULE7
        sel_now == SEL_AUX_REF
        |=> !shared_test_lock_pin_oe_b && shared_test_lock_pin_o == $past(aux_in.ref_div))
        else $error("aux reference divider not on shared pin");

    chk_main_ref: assert property ( // see RULE7
        sel_now == SEL_MAIN_REF
        |=> !shared_test_lock_pin_oe_b && shared_test_lock_pin_o == $past(main_in.ref_div))
        else $error("main reference divider not on shared pin");

    chk_main_fb: assert property ( // see RULE7
        sel_now == SEL_MAIN_FB
        |=> !shared_test_lock_pin_oe_b && shared_test_lock_pin_o == $past(main_in.fb_div))
        else $error("main feedback divider not on shared pin");

    chk_fast_open: assert property ( // see RULE8
        sel_now == SEL_FAST && !main_in.pump_busy && !st_q.main_mode.quad
        |=> shared_test_lock_pin_oe_b)
        else $error("fast acquire switch grounded at base current");

    chk_rst_pin: assert property ( // see RULE9
        sel_now == SEL_RST |=> shared_test_lock_pin_oe_b)
        else $error("shared pin driven in counter reset mode");

    // Loop controls
    chk_aux_reset: assert property ( // see RULE9
        sel_now == SEL_RST && st_q.aux_mode.sel_lo |=> aux_out.cnt_reset && aux_out.hiz)
        else $error("aux counters not held in reset");

    chk_cnt_release: assert property ( // see RULE10
        sel_now != SEL_RST |=> !aux_out.cnt_reset && !main_out.cnt_reset)
        else $error("counter reset held after selection removed");

    chk_main_quad_hold: assert property ( // see RULE13
        main_in.pump_busy |=> $stable(main_out.quad))
        else $error("main pump current changed during pump pulse");

    chk_pol_pass: assert property ( // see RULE14
        1'b1 |=> aux_out.pol == $past(st_q.aux_mode.pol) && main_out.pol == $past(st_q.main_mode.pol))
        else $error("detector polarity not passed to loops");

    // Main scenarios that must be reached
    cov_fast: cover property (sel_now == SEL_FAST ##1 !shared_test_lock_pin_oe_b);
    cov_lock_both: cover property (sel_now == SEL_LD_BOTH ##1 shared_test_lock_pin_oe_b);
    cov_reset_all: cover property (aux_out.cnt_reset && main_out.cnt_reset);
    cov_pd_wait: cover property (st_q.aux_pd == PD_WAIT ##[1:20] aux_out.power_down);
    cov_main_fb: cover property (sel_now == SEL_MAIN_FB ##1 !shared_test_lock_pin_oe_b);
endmodule

`default_nettype wire

// ---- design/sml_pkg.sv ----
// Shared constants and types for the synthesizer mode and test/lock output block
package sml_pkg;

    // Serial word layout
    localparam int SHIFT_W = 22;
    localparam int ADDR_W = 2;
    localparam int BIT_POL = 15;
    localparam int BIT_QUAD = 16;
    localparam int BIT_HIZ = 17;
    localparam int BIT_SEL_LO = 18;
    localparam int BIT_SEL_HI = 19;
    localparam int BIT_LOOP_POWER_DOWN_BIT = 21;
    localparam int MODE_W = 5;

    // Address field codes
    localparam logic [1:0] ADDR_AUX_R = 2'h0;
    localparam logic [1:0] ADDR_AUX_N = 2'h1;
    localparam logic [1:0] ADDR_MAIN_R = 2'h2;
    localparam logic [1:0] ADDR_MAIN_N = 2'h3;

    // Synchroniser depth and reset values
    localparam int SYNC_STAGES = 2;
    localparam logic [SHIFT_W-1:0] SHIFT_RESET = 22'h000000;
    localparam logic PIN_OE_B_RESET = 1'b1;

    // Mode bits of one reference word, bit 19 down to bit 15
    typedef struct packed {
        logic sel_hi;
        logic sel_lo;
        logic hiz;
        logic quad;
        logic pol;
    } sml_mode_t;

    localparam sml_mode_t MODE_RESET = 5'h00;

    // Function of the shared test/lock pin
    typedef enum logic [9:0] {
        SEL_OFF      = 10'h001,
        SEL_LD_AUX   = 10'h002,
        SEL_LD_MAIN  = 10'h004,
        SEL_LD_BOTH  = 10'h008,
        SEL_AUX_REF  = 10'h010,
        SEL_MAIN_REF = 10'h020,
        SEL_AUX_FB   = 10'h040,
        SEL_MAIN_FB  = 10'h080,
        SEL_FAST     = 10'h100,
        SEL_RST      = 10'h200
    } sml_sel_t;

    // Power-down sequencing per loop
    typedef enum logic [2:0] {
        PD_RUN  = 3'h1,
        PD_WAIT = 3'h2,
        PD_DOWN = 3'h4
    } sml_pd_t;

    // Status coming from one loop's analog/counter logic
    typedef struct packed {
        logic lock;
        logic ref_div;
        logic fb_div;
        logic pump_busy;
    } sml_loop_in_t;

    // Controls going to one loop
    typedef struct packed {
        logic hiz;
        logic quad;
        logic pol;
        logic cnt_reset;
        logic power_down;
    } sml_loop_out_t;

    // Serial-clock domain state
    typedef struct packed {
        logic [SHIFT_W-1:0] shift;
    } sml_link_st_t;

    // Reference-clock domain state
    typedef struct packed {
        logic le_prev;
        sml_mode_t aux_mode;
        sml_mode_t main_mode;
        logic aux_loop_power_down_bit;
        logic main_loop_power_down_bit;
        logic aux_quad_app;
        logic main_quad_app;
        sml_pd_t aux_pd;
        sml_pd_t main_pd;
        sml_loop_out_t aux_out;
        sml_loop_out_t main_out;
        logic pin_o;
        logic pin_oe_b;
    } sml_ref_st_t;

endpackage

// ---- design/sml_sync.sv ----
// Two-flop level synchroniser into the reference clock domain
`timescale 1ns/1ps
`default_nettype none

module sml_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sml_sync_st_t;

    sml_sync_st_t st_q;
    sml_sync_st_t st_d;

    // First stage only feeds the second
    always_comb begin
        st_d = st_q;
        st_d.meta = d;
        st_d.sync = st_q.meta;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.sync;
endmodule

`default_nettype wire

// ---- test/sml_ctrl_model.sv ----
// Behavioural baseband controller that loads words over the three-wire link
`timescale 1ns/1ps
`default_nettype none

module sml_ctrl_model (
    input wire logic start,
    input wire logic [21:0] word,
    output logic busy,
    output logic ser_clk,
    output logic ser_data,
    output logic load_strobe
);
    // Idle link: clock parked low, strobe low; one frame per start pulse
    initial begin
        busy = 1'b0;
        ser_clk = 1'b0;
        ser_data = 1'b0;
        load_strobe = 1'b0;
        forever begin
            @(posedge start);
            busy = 1'b1;
            // Odd offset keeps phase unrelated to ref_clk
            #37;
            for (int i = 21; i >= 0; i--) begin
                ser_data = word[i];
                #80 ser_clk = 1'b1;
                #80 ser_clk = 1'b0;
            end
            // Released data line must not look like a held bit
            ser_data = ~ser_data;
            // Clock stays parked while the strobe moves the word
            #100 load_strobe = 1'b1;
            #300 load_strobe = 1'b0;
            #300 busy = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the mode control and shared test/lock pin block
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import sml_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic start = 1'b0;
    logic [SHIFT_W-1:0] word = '0;
    logic busy;
    logic ser_clk;
    logic ser_data;
    logic load_strobe;
    sml_loop_in_t aux_in = '0;
    sml_loop_in_t main_in = '0;
    sml_loop_out_t aux_out;
    sml_loop_out_t main_out;
    logic pin_o;
    logic pin_oe_b;
    logic [1:0] pin;
    logic exp;
    int error_cnt = 0;
    int checks = 0;

    assign pin = {pin_oe_b, pin_o};

    // 20 MHz reference clock
    always #25 ref_clk = ~ref_clk;

    sml_mode_ctrl sml_mode_ctrl_i (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .load_strobe(load_strobe),
        .aux_in(aux_in),
        .main_in(main_in),
        .aux_out(aux_out),
        .main_out(main_out),
        .shared_test_lock_pin_o(pin_o),
        .shared_test_lock_pin_oe_b(pin_oe_b)
    );

    sml_ctrl_model sml_ctrl_model_i (
        .start(start),
        .word(word),
        .busy(busy),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .load_strobe(load_strobe)
    );

    // Verdict and end of run
    task automatic test_done();
        if (error_cnt == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] got);
        checks++;
        if (got !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Full frame through the controller model, bounded wait for its end
    task automatic send(input logic [SHIFT_W-1:0] w);
        int n;
        word = w;
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        n = 0;
        while (busy === 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        if (n >= 400) begin
            error_cnt++;
            $display("[ERR] serial load expected done seen busy");
            test_done();
        end
        cyc(3);
    endtask

    // Reference word: mode bits 19..15, dummy divider ratio, address
    function automatic logic [SHIFT_W-1:0] rw(input logic [4:0] m, input logic [1:0] a);
        return {2'h0, m, 13'h0003, a};
    endfunction

    // Main sequence, inputs change on falling edges only
    initial begin
        cyc(5);
        rst_b = 1'b1;
        cyc(2);
        chk("aux_out", 5'h00, aux_out);
        chk("main_out", 5'h00, main_out);
        chk("pin", 5'h02, {3'h0, pin});
        send(rw(5'h03, ADDR_AUX_R));
        chk("aux_out", 5'h0c, aux_out);
        chk("main_out", 5'h00, main_out);
        send(rw(5'h04, ADDR_MAIN_R));
        chk("main_out", 5'h10, main_out);
        // Every lock-detect selection against every lock combination
        for (int k = 0; k < 4; k++) begin
            send(rw({1'b0, k[0], 3'h3}, ADDR_AUX_R));
            send(rw({1'b0, k[1], 3'h4}, ADDR_MAIN_R));
            for (int l = 0; l < 4; l++) begin
                aux_in.lock = l[0];
                main_in.lock = l[1];
                cyc(2);
                exp = (k == 0) ? 1'b1 : (k == 1) ? l[0] : (k == 2) ? l[1] : (l[0] & l[1]);
                chk("pin", {3'h0, exp, 1'b0}, {3'h0, pin});
            end
        end
        // Divider routing; loops given opposite phases to tell them apart
        for (int c = 0; c < 4; c++) begin
            send(rw({~c[1], c[0], 3'h3}, ADDR_AUX_R));
            send(rw({c[1], ~c[0], 3'h4}, ADDR_MAIN_R));
            for (int v = 0; v < 2; v++) begin
                aux_in.ref_div = v[0];
                aux_in.fb_div = ~v[0];
                main_in.ref_div = ~v[0];
                main_in.fb_div = v[0];
                cyc(2);
                chk("pin", {4'h0, v[0] ^ c[0] ^ c[1]}, {3'h0, pin});
            end
        end
        // Fast acquire, then base current requested during a pump pulse, applied after it
        send(rw(5'h13, ADDR_AUX_R));
        send(rw(5'h12, ADDR_MAIN_R));
        chk("pin", 5'h00, {3'h0, pin});
        chk("main_out", 5'h08, main_out);
        main_in.pump_busy = 1'b1;
        send(rw(5'h10, ADDR_MAIN_R));
        chk("main_out", 5'h08, main_out);
        chk("pin", 5'h00, {3'h0, pin});
        main_in.pump_busy = 1'b0;
        cyc(3);
        chk("main_out", 5'h00, main_out);
        chk("pin", 5'h02, {3'h0, pin});
        // Counter resets, one loop then both, then release
        send(rw(5'h1b, ADDR_AUX_R));
        chk("aux_out", 5'h1e, aux_out);
        chk("main_out", 5'h00, main_out);
        send(rw(5'h18, ADDR_MAIN_R));
        chk("main_out", 5'h12, main_out);
        chk("aux_out", 5'h1e, aux_out);
        chk("pin released", 5'h01, {4'h0, pin_oe_b});
        send(rw(5'h03, ADDR_AUX_R));
        chk("aux_out", 5'h0c, aux_out);
        chk("main_out", 5'h00, main_out);
        // Gated power-down waits for the pump pulse, loads still work
        aux_in.pump_busy = 1'b1;
        send({1'b1, 19'h0, ADDR_AUX_N});
        chk("aux_out", 5'h0c, aux_out);
        aux_in.pump_busy = 1'b0;
        cyc(3);
        chk("aux_out", 5'h0d, aux_out);
        send(rw(5'h01, ADDR_AUX_R));
        chk("aux_out", 5'h05, aux_out);
        // High-impedance loop powers down at once despite a busy pump
        send(rw(5'h04, ADDR_MAIN_R));
        main_in.pump_busy = 1'b1;
        send({1'b1, 19'h0, ADDR_MAIN_N});
        chk("main_out", 5'h11, main_out);
        main_in.pump_busy = 1'b0;
        // Aux powered up again, then down at once in high impedance
        send({1'b0, 19'h0, ADDR_AUX_N});
        chk("aux_out", 5'h04, aux_out);
        send(rw(5'h05, ADDR_AUX_R));
        aux_in.pump_busy = 1'b1;
        send({1'b1, 19'h0, ADDR_AUX_N});
        chk("aux_out", 5'h15, aux_out);
        aux_in.pump_busy = 1'b0;
        test_done();
    end
endmodule
`default_nettype wire
